/* core/fbr_fan_boost_ramp.sv */
// Purpose: Ramp step delays, fan boost hysteresis and spike smoothing.
// Assumes: Overheat pins are asynchronous and active low; all else is local.
// Notes: Long cycle counts are parameters so simulation can shorten them.
`default_nettype none
module fbr_fan_boost_ramp
	import fbr_pkg::*;
#(
	parameter int STEP_UNIT_CYCLES = FBR_STEP_UNIT_CYCLES,
	parameter int CYCLES_PER_DS = FBR_CYCLES_PER_DS
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire fbr_reg_req_t regReq,
	output logic [7:0] regRdData_q,
	input wire logic regulatorOverheatInN,
	input wire logic processorOverheatInN,
	input wire fbr_zone_temps_t rawTemps,
	input wire fbr_zone_temps_t boostTemps,
	input wire logic [7:0] autoDuty,
	output logic [7:0] pwmDuty_q,
	output fbr_zone_temps_t readTemps_q,
	output fbr_zone_temps_t controlTemps_q,
	output logic [1:0][11:0] filteredTemps_q,
	output logic [3:0] boostActive_q
);
	// Software-visible registers and their next values.
	logic [7:0] rampCtl_q, rampCtl_d;
	logic [7:0] hyst12_q, hyst12_d;
	logic [7:0] hyst34_q, hyst34_d;
	logic [7:0] smooth12_q, smooth12_d;
	logic [7:0] rdData_d;
	// Two-stage synchronisers for the overheat pins, index 0 regulator.
	logic [1:0] hotMeta_q, hotSync_q;
	// Per-ramp duty and delay counter.
	logic [1:0][7:0] rampDuty_q, rampDuty_d;
	logic [1:0][23:0] rampCnt_q, rampCnt_d;
	// Per-zone filter accumulator and update timer.
	logic [1:0][11:0] filt_d;
	logic [1:0][23:0] filtCnt_q, filtCnt_d;
	// Boost latches and the outputs' next values.
	logic [3:0] boost_d;
	logic [7:0] duty_d;
	fbr_zone_temps_t control_d;

	// Writes land on the addressed register; reads return it, else zero.
	always_comb begin
		rampCtl_d = rampCtl_q;
		hyst12_d = hyst12_q;
		hyst34_d = hyst34_q;
		smooth12_d = smooth12_q;
		rdData_d = regRdData_q;
		if (regReq.wrEn) begin
			unique case (regReq.addr)
				FBR_ADDR_RAMP: rampCtl_d = regReq.wrData;
				FBR_ADDR_HYST12: hyst12_d = regReq.wrData;
				FBR_ADDR_HYST34: hyst34_d = regReq.wrData;
				FBR_ADDR_SMOOTH12: smooth12_d = regReq.wrData;
				default: begin
					// Unmapped writes are dropped.
				end
			endcase
		end
		if (regReq.rdEn) begin
			unique case (regReq.addr)
				FBR_ADDR_RAMP: rdData_d = rampCtl_q;
				FBR_ADDR_HYST12: rdData_d = hyst12_q;
				FBR_ADDR_HYST34: rdData_d = hyst34_q;
				FBR_ADDR_SMOOTH12: rdData_d = smooth12_q;
				default: rdData_d = 8'h00;
			endcase
		end
	end

	// Register file and read data, plus the pin synchronisers.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rampCtl_q <= FBR_RST_RAMP;
			hyst12_q <= FBR_RST_HYST;
			hyst34_q <= FBR_RST_HYST;
			smooth12_q <= FBR_RST_SMOOTH;
			regRdData_q <= 8'h00;
			hotMeta_q <= 2'b00;
			hotSync_q <= 2'b00;
		end else begin
			rampCtl_q <= rampCtl_d;
			hyst12_q <= hyst12_d;
			hyst34_q <= hyst34_d;
			smooth12_q <= smooth12_d;
			regRdData_q <= rdData_d;
			// Pins are active low; invert before the first stage.
			hotMeta_q <= ~{processorOverheatInN, regulatorOverheatInN};
			hotSync_q <= hotMeta_q;
		end
	end

	// One ramp per overheat source. While the source is hot the duty climbs
	// one step per delay expiry; once it clears the duty falls the same way.
	for (genvar r = 0; r < 2; r++) begin : gRamp
		logic [3:0] code;
		logic [23:0] limit;
		logic moving;
		assign code = (r == 0) ? rampCtl_q[FBR_LO_NIB_LSB +: 4]
			: rampCtl_q[FBR_HI_NIB_LSB +: 4];
		// Delay is code times the 50 ms unit.
		assign limit = 24'(int'(code) * STEP_UNIT_CYCLES);
		assign moving = hotSync_q[r] ? (rampDuty_q[r] != FBR_DUTY_FULL)
			: (rampDuty_q[r] != FBR_DUTY_OFF);

		always_comb begin
			rampDuty_d[r] = rampDuty_q[r];
			rampCnt_d[r] = 24'h0000;
			if (code == 4'h0) begin
				// No delay means no gradual slope at all.
				rampDuty_d[r] = hotSync_q[r] ? FBR_DUTY_FULL
					: FBR_DUTY_OFF;
			end else if (moving) begin
				if (rampCnt_q[r] >= limit - 24'h0001) begin
					// Saturating step keeps the duty inside its range.
					if (hotSync_q[r]) begin
						rampDuty_d[r] = (rampDuty_q[r] > FBR_DUTY_FULL -
							FBR_RAMP_STEP) ? FBR_DUTY_FULL
							: rampDuty_q[r] + FBR_RAMP_STEP;
					end else begin
						rampDuty_d[r] = (rampDuty_q[r] < FBR_RAMP_STEP) ?
							FBR_DUTY_OFF
							: rampDuty_q[r] - FBR_RAMP_STEP;
					end
				end else begin
					rampCnt_d[r] = rampCnt_q[r] + 24'h0001;
				end
			end
		end

		always_ff @(posedge clk) begin
			if (sys_rst) begin
				rampDuty_q[r] <= FBR_DUTY_OFF;
				rampCnt_q[r] <= 24'h0000;
			end else begin
				rampDuty_q[r] <= rampDuty_d[r];
				rampCnt_q[r] <= rampCnt_d[r];
			end
		end
	end

	// Spike smoothing for zones 1 and 2. The average moves a sixteenth of the
	// way toward the raw value per update, so sixteen updates span the window.
	// This costs precision on short windows but needs no sample memory.
	for (genvar z = 0; z < 2; z++) begin : gSmooth
		logic [2:0] win;
		logic [23:0] span;
		logic signed [12:0] diff;
		assign win = smooth12_q[(z == 0 ? FBR_Z1_WIN_LSB : FBR_Z2_WIN_LSB) +: 3];
		// Cycles between updates for the selected window.
		assign span = 24'(FBR_SPAN_DS[win] * CYCLES_PER_DS /
			FBR_FILT_UPDATES);
		assign diff = $signed({rawTemps.temp[z][7], rawTemps.temp[z],
			4'h0}) - $signed({filteredTemps_q[z][11], filteredTemps_q[z]});

		always_comb begin
			filt_d[z] = filteredTemps_q[z];
			filtCnt_d[z] = filtCnt_q[z] + 24'h0001;
			// Runs whatever the use bit says, so software can always read it.
			if (filtCnt_q[z] >= span - 24'h0001) begin
				filtCnt_d[z] = 24'h0000;
				filt_d[z] = filteredTemps_q[z] +
					12'(diff >>> FBR_FILT_SHIFT);
			end
		end

		always_ff @(posedge clk) begin
			if (sys_rst) begin
				filteredTemps_q[z] <= 12'h000;
				filtCnt_q[z] <= 24'h0000;
			end else begin
				filteredTemps_q[z] <= filt_d[z];
				filtCnt_q[z] <= filtCnt_d[z];
			end
		end
	end

	// Pick the temperature that limits and fan control see per zone.
	always_comb begin
		control_d = rawTemps;
		if (smooth12_q[FBR_Z1_USE_BIT]) begin
			control_d.temp[0] = filteredTemps_q[0][11:4];
		end
		if (smooth12_q[FBR_Z2_USE_BIT]) begin
			control_d.temp[1] = filteredTemps_q[1][11:4];
		end
	end

	// Boost latch per zone: set above the boost point, released only once the
	// zone is below it by the hysteresis. Nine bits avoid wrap at the ends.
	for (genvar b = 0; b < 4; b++) begin : gBoost
		logic [3:0] hyst;
		logic signed [8:0] temp9, boost9, release9;
		assign hyst = (b < 2) ? hyst12_q[(b % 2) * 4 +: 4]
			: hyst34_q[(b % 2) * 4 +: 4];
		assign temp9 = $signed({control_d.temp[b][7], control_d.temp[b]});
		assign boost9 = $signed({boostTemps.temp[b][7], boostTemps.temp[b]});
		// Hysteresis is zero-extended, never sign-extended.
		assign release9 = boost9 - $signed({5'b00000, hyst});
		always_comb begin
			boost_d[b] = boostActive_q[b];
			if (temp9 > boost9) begin
				boost_d[b] = 1'b1;
			end else if (temp9 < release9) begin
				boost_d[b] = 1'b0;
			end
		end
	end

	// Final duty: boost forces full, else the largest request wins.
	always_comb begin
		duty_d = autoDuty;
		if (rampDuty_q[0] > duty_d) begin
			duty_d = rampDuty_q[0];
		end
		if (rampDuty_q[1] > duty_d) begin
			duty_d = rampDuty_q[1];
		end
		if (|boost_d) begin
			duty_d = FBR_DUTY_FULL;
		end
	end

	// Output registers; reading temperatures always carry raw values.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pwmDuty_q <= FBR_DUTY_OFF;
			boostActive_q <= 4'h0;
			readTemps_q <= '0;
			controlTemps_q <= '0;
		end else begin
			pwmDuty_q <= duty_d;
			boostActive_q <= boost_d;
			readTemps_q <= rawTemps;
			controlTemps_q <= control_d;
		end
	end
endmodule : fbr_fan_boost_ramp
`default_nettype wire

/* common/fbr_pkg.sv */
// Purpose: Shared constants and carrier types of the fan boost and ramp block.
// Assumes: Byte-wide registers at their device offsets; 10 MHz core clock.
// Notes: Temperatures are signed whole degrees; filtered ones carry 4 fraction
//        bits.
`default_nettype none
package fbr_pkg;
	// Register offsets on the byte-wide host register port.
	localparam logic [7:0] FBR_ADDR_RAMP = 8'hbf;
	localparam logic [7:0] FBR_ADDR_HYST12 = 8'hc0;
	localparam logic [7:0] FBR_ADDR_HYST34 = 8'hc1;
	localparam logic [7:0] FBR_ADDR_SMOOTH12 = 8'hc2;
	// Values after reset.
	localparam logic [7:0] FBR_RST_RAMP = 8'h00;
	localparam logic [7:0] FBR_RST_HYST = 8'h44;
	localparam logic [7:0] FBR_RST_SMOOTH = 8'h00;
	// Field positions: low nibble is zone 1/3 or regulator, high the other.
	localparam int FBR_LO_NIB_LSB = 0;
	localparam int FBR_HI_NIB_LSB = 4;
	localparam int FBR_Z1_WIN_LSB = 0;
	localparam int FBR_Z1_USE_BIT = 3;
	localparam int FBR_Z2_WIN_LSB = 4;
	localparam int FBR_Z2_USE_BIT = 7;
	// Duty values; full duty is the all-ones code.
	localparam logic [7:0] FBR_DUTY_FULL = 8'hff;
	localparam logic [7:0] FBR_DUTY_OFF = 8'h00;
	localparam logic [7:0] FBR_RAMP_STEP = 8'h10;
	// Ramp step unit, 50 ms per code, and the cycles it takes at 10 MHz.
	localparam int FBR_STEP_UNIT_MS = 50;
	localparam int FBR_CLK_KHZ = 10_000;
	localparam int FBR_STEP_UNIT_CYCLES = FBR_STEP_UNIT_MS * FBR_CLK_KHZ;
	// Smoothing spans in tenths of a second for window codes 0 to 7.
	localparam int FBR_SPAN_DS [8] = '{118, 70, 44, 30, 16, 8, 6, 4};
	localparam int FBR_CYCLES_PER_DS = FBR_CLK_KHZ * 100;
	// The filter is a first-order average with this shift per update.
	localparam int FBR_FILT_SHIFT = 4;
	localparam int FBR_FILT_UPDATES = 1 << FBR_FILT_SHIFT;
	// Host register access request, one cycle per access.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wrData;
		logic wrEn;
		logic rdEn;
	} fbr_reg_req_t;
	// Four zone temperatures, zone 1 in the lowest byte.
	typedef struct packed {
		logic [3:0][7:0] temp;
	} fbr_zone_temps_t;
endpackage : fbr_pkg
`default_nettype wire

/* bench/fbr_fan_boost_ramp_props.sv */
// Purpose: Port-level checker for the fan boost and ramp block.
// Assumes: One clock domain; register shadow kept from write strobes.
// Notes: Bound to every instance of the block.
`default_nettype none
module fbr_fan_boost_ramp_props
	import fbr_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire fbr_reg_req_t regReq,
	input wire logic [7:0] regRdData_q,
	input wire logic processorOverheatInN,
	input wire fbr_zone_temps_t rawTemps,
	input wire logic [7:0] pwmDuty_q,
	input wire fbr_zone_temps_t readTemps_q,
	input wire fbr_zone_temps_t controlTemps_q,
	input wire logic [3:0] boostActive_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Shadow copy of the four registers, index 0 is the ramp register.
	logic [3:0][7:0] shQ, shD;
	logic [7:0] idx;
	logic hit;
	logic [7:0] rdSel;
	logic useOff;
	assign idx = regReq.addr - FBR_ADDR_RAMP;
	assign hit = regReq.addr >= FBR_ADDR_RAMP &&
		regReq.addr <= FBR_ADDR_SMOOTH12;
	assign rdSel = shQ[idx[1:0]];
	// The zone 1 use bit must be clear now and after this edge.
	assign useOff = !shQ[3][FBR_Z1_USE_BIT] && !shD[3][FBR_Z1_USE_BIT];
	// Next shadow value follows accepted writes.
	always_comb begin
		shD = shQ;
		if (regReq.wrEn && hit) begin
			shD[idx[1:0]] = regReq.wrData;
		end
	end
	// Shadow register with the documented reset values.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shQ <= {FBR_RST_SMOOTH, FBR_RST_HYST, FBR_RST_HYST, FBR_RST_RAMP};
		end else begin
			shQ <= shD;
		end
	end
	sequence s_fastFull;
		##[1:6] pwmDuty_q == FBR_DUTY_FULL;
	endsequence
	a_unmapped_read: assert property (
		regReq.rdEn && !hit |=> regRdData_q == 8'h00)
		else $error("unmapped read not zero");
	a_reg_readback: assert property (
		regReq.rdEn && hit |=> regRdData_q == $past(rdSel))
		else $error("register read differs from shadow");
	a_read_hold: assert property (
		!regReq.rdEn |=> $stable(regRdData_q))
		else $error("read data moved without a read");
	a_read_raw: assert property (
		1'b1 |=> readTemps_q == $past(rawTemps))
		else $error("reading temps not raw");
	a_zone_four_raw: assert property (
		1'b1 |=> controlTemps_q.temp[3] == $past(rawTemps.temp[3]))
		else $error("zone 4 control temp not raw");
	a_zone_one_raw: assert property (
		useOff |=> controlTemps_q.temp[0] == $past(rawTemps.temp[0]))
		else $error("zone 1 control temp filtered while off");
	a_boost_full: assert property (
		boostActive_q != 4'h0 && $past(boostActive_q) != 4'h0 |->
		pwmDuty_q == FBR_DUTY_FULL)
		else $error("boost active without full duty");
	a_fast_ramp: assert property (
		$fell(processorOverheatInN) && shQ[0][7:4] == 4'h0 |-> s_fastFull)
		else $error("zero delay did not reach full duty");
endmodule : fbr_fan_boost_ramp_props
bind fbr_fan_boost_ramp fbr_fan_boost_ramp_props u_props (
	.clk,
	.sys_rst,
	.regReq,
	.regRdData_q,
	.processorOverheatInN,
	.rawTemps,
	.pwmDuty_q,
	.readTemps_q,
	.controlTemps_q,
	.boostActive_q
);
`default_nettype wire

/* bench/fbr_fan_boost_ramp_tb.sv */
// Purpose: Self-checking bench for the fan boost and ramp block.
// Assumes: Short step unit and filter period parameters.
// Notes: Scenarios run in sequence from one reset.
`default_nettype none
module fan_boost_ramp_smoothing_tb;
	import fbr_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int STEP = 4;
	logic clk = 1'b0, sys_rst = 1'b1, regN = 1'b1, procN = 1'b1;
	fbr_reg_req_t req = '0;
	fbr_zone_temps_t raw = {8'h00, 8'h00, 8'h40, 8'h14};
	fbr_zone_temps_t bst = {8'h7f, 8'h7f, 8'h7f, 8'h32};
	logic [7:0] autoD = 8'h00, rdD, duty;
	fbr_zone_temps_t rdT, ctlT;
	logic [1:0][11:0] filt;
	logic [3:0] boost;
	int failures = 0, num_checks = 0, cyc = 0, n;
	fbr_fan_boost_ramp #(
		.STEP_UNIT_CYCLES(STEP),
		.CYCLES_PER_DS(160)
	) fbr_fan_boost_ramp_inst (
		.clk(clk),
		.sys_rst(sys_rst),
		.regReq(req),
		.regRdData_q(rdD),
		.regulatorOverheatInN(regN),
		.processorOverheatInN(procN),
		.rawTemps(raw),
		.boostTemps(bst),
		.autoDuty(autoD),
		.pwmDuty_q(duty),
		.readTemps_q(rdT),
		.controlTemps_q(ctlT),
		.filteredTemps_q(filt),
		.boostActive_q(boost)
	);
	initial begin
		forever #50 clk = ~clk;
	end
	// Cycle ceiling that cuts a hang short.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures = failures + 1;
			conclude();
		end
	end
	task automatic check(input string nm, input logic [11:0] s,
		input logic [11:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic waitn(input int k);
		repeat (k) @(posedge clk);
	endtask : waitn
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) req.wrEn <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk) req.rdEn <= 1'b0;
		#1 check("read", rdD, e);
	endtask : rd
	// Counts cycles until the duty shows v, at most lim.
	task automatic waitDuty(input logic [7:0] v, input int lim);
		n = 0;
		while (duty !== v && n < lim) begin
			waitn(1);
			#1 n++;
		end
		check("duty reached", duty, v);
	endtask : waitDuty
	task automatic t_regs();
		rd(FBR_ADDR_RAMP, FBR_RST_RAMP);
		rd(FBR_ADDR_HYST12, 8'h44);
		rd(FBR_ADDR_HYST34, 8'h44);
		rd(FBR_ADDR_SMOOTH12, 8'h00);
		rd(8'hc3, 8'h00);
		wr(FBR_ADDR_HYST34, 8'ha5);
		rd(FBR_ADDR_HYST34, 8'ha5);
	endtask : t_regs
	task automatic t_smooth();
		// Both zones on the shortest window; only zone 2 uses its average.
		wr(FBR_ADDR_SMOOTH12, 8'hf7);
		waitn(60);
		#1 check("raw reading", rdT.temp[1], 8'h40);
		check("filtered control", ctlT.temp[1] < 8'h40, 1'b1);
		check("zone1 control raw", ctlT.temp[0], 8'h14);
		check("filter runs", filt[0] != 12'h000, 1'b1);
	endtask : t_smooth
	task automatic t_ramp();
		wr(FBR_ADDR_RAMP, 8'h02);
		regN <= 1'b0;
		waitDuty(8'h10, 40);
		waitDuty(8'h20, 40);
		check("step spacing", n >= 2 * STEP && n <= 2 * STEP + 2, 1'b1);
		@(posedge clk) regN <= 1'b1;
		waitDuty(8'h10, 40);
	endtask : t_ramp
	task automatic t_boost();
		waitn(30);
		// Hysteresis 12 has its top bit set, so a sign slip would show.
		wr(FBR_ADDR_HYST12, 8'h4c);
		autoD <= 8'h20;
		raw.temp[0] <= 8'h33;
		waitn(4);
		#1 check("boost set", boost[0], 1'b1);
		// Below the boost point, but not yet by the full hysteresis.
		@(posedge clk) raw.temp[0] <= 8'h30;
		waitn(4);
		#1 check("boost held", duty, FBR_DUTY_FULL);
		// One degree below the release point of 50 minus 12.
		@(posedge clk) raw.temp[0] <= 8'h25;
		waitn(4);
		#1 check("boost released", duty, 8'h20);
	endtask : t_boost
	task automatic t_fast();
		@(posedge clk) procN <= 1'b0;
		waitn(8);
		#1 check("instant full", duty, FBR_DUTY_FULL);
	endtask : t_fast
	task automatic conclude();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude
	initial begin
		waitn(3);
		sys_rst <= 1'b0;
		t_regs();
		t_smooth();
		t_ramp();
		t_boost();
		t_fast();
		conclude();
	end
endmodule : fan_boost_ramp_smoothing_tb
`default_nettype wire
